/* rtl/pad_consts.svh */
/*
   register offsets, field positions, reset values and datapath widths of the power accumulator datapath.
   assumes it is included by bare name from the design files; definitions only.
*/
// Function
// [RL1] each channel keeps rolling eight-sample averages of bus and sense voltage, per conversion
// [RL2] readable results, averages included, change only on one of three snapshot commands
// [RL3] averages are valid only after eight conversions since reset
// [RL4] permutation position per input steps through four positions in four conversions
// [RL5] internal bus and sense samples are 17-bit signed numbers
// [RL6] sign-format register selects signed or unsigned results for bus and sense separately
// [RL7] unsigned format exports sixteen unsigned sample bits to readable registers
// [RL8] signed bus format truncates the sample to 16-bit two's complement
// [RL9] signed sense is truncated for reading, power uses full 17-bit sample
// [RL10] power equals sense sample times top 14 bus bits, 31-bit signed
// [RL11] multiply and accumulate always use two's complement arithmetic
// [RL12] every power product is added to its channel accumulator and readable
// [RL13] reported power is 28 bits, accumulator is 48 bits
// [RL14] sample counter is 24 bits wide
// [RL15] counter overflow wraps and does not clear the counter
// [RL16] accumulator saturates at its limit and does not wrap
// [RL17] accumulator saturation is reportable through the alert output
// [RL18] host selects the sample rate; device accumulates at that rate
// [RL19] accumulated power is signed when bus or sense format is signed
// [RL20] power is computed and accumulated right after each channel conversion
// [RL21] overflow flag stays set until plain or general snapshot; no-clear snapshot keeps it
// [RL22] clearing snapshots zero accumulators and counter after latching them
// [RL23] overflow flag sets in the cycle of saturation or counter wrap
`ifndef PAD_CONSTS_SVH
`define PAD_CONSTS_SVH

// ==========================================================
// register map
`define PAD_ADDR_CTRL 8'h01
`define PAD_ADDR_SIGN_FMT 8'h1d
`define PAD_CTRL_RST 8'h00
`define PAD_SIGN_FMT_RST 8'h00
`define PAD_CTRL_RATE_LSB 6
`define PAD_CTRL_ALERT_BIT 1
`define PAD_CTRL_OVF_BIT 0
`define PAD_SFMT_BUS_BIT 3
`define PAD_SFMT_SENSE_BIT 2

// ==========================================================
// datapath sizes
`define PAD_SAMPLE_W 17
`define PAD_BUS_MSBS 14
`define PAD_PROD_W 31
`define PAD_PWR_W 28
`define PAD_ACC_W 48
`define PAD_CNT_W 24
`define PAD_AVG_DEPTH 8

`endif

/* rtl/pad_pkg.sv */
/*
   types shared by the power accumulator datapath modules.
   assumes at most four channels, addressed by a two-bit index.
*/
package pad_pkg;

   // one finished conversion of one channel
   typedef struct packed {
      logic valid;
      logic [1:0] chan;
      logic signed [16:0] bus;
      logic signed [16:0] sense;
   } pad_sample_type;

   // snapshot commands from the serial front end, one-cycle pulses
   typedef struct packed {
      logic plain;
      logic no_clear;
      logic general;
   } pad_snap_type;

   typedef enum logic [2:0] {
      RES_BUS = 3'b000,
      RES_SENSE = 3'b001,
      RES_BUS_AVG = 3'b010,
      RES_SENSE_AVG = 3'b011,
      RES_POWER = 3'b100,
      RES_ACC = 3'b101,
      RES_COUNT = 3'b110
   } pad_res_sel_type;

   typedef enum logic [1:0] {
      RATE_1024 = 2'b00,
      RATE_256 = 2'b01,
      RATE_64 = 2'b10,
      RATE_8 = 2'b11
   } pad_rate_type;

endpackage

/* rtl/pad_avg8.sv */
/*
   rolling average over the most recent DEPTH samples of one signed input.
   assumes DEPTH is a power of two; push is a one-cycle pulse per conversion.
*/
`timescale 1ns/1ps
`include "pad_consts.svh"

module pad_avg8 #(
   parameter int W = `PAD_SAMPLE_W,
   parameter int DEPTH = `PAD_AVG_DEPTH
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic push,
   input wire logic signed [W-1:0] din,
   output logic signed [W-1:0] avg,
   output logic full
);
   import pad_pkg::*;

   localparam int PW = $clog2(DEPTH);
   localparam int SW = W + PW;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] win;
      logic [PW-1:0] ptr;
      logic signed [SW-1:0] sum;
      logic [PW:0] cnt;
   } avg_st_type;

   avg_st_type st_q;
   avg_st_type st_d;

   // ==========================================================
   // window update: the running sum swaps the oldest entry for the newest
   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.sum = st_q.sum + SW'(din) - SW'($signed(st_q.win[st_q.ptr])); // RL1
         st_d.win[st_q.ptr] = din;
         st_d.ptr = PW'(st_q.ptr + 1'b1);
         if (st_q.cnt != (PW+1)'(DEPTH)) begin
            st_d.cnt = (PW+1)'(st_q.cnt + 1'b1); // RL3
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign avg = W'(st_q.sum >>> PW);
   assign full = (st_q.cnt == (PW+1)'(DEPTH));

endmodule // pad_avg8

/* rtl/pad_datapath.sv */
/*
   per-channel measurement datapath: averaging, permutation stepping, power product,
   result formatting, saturating accumulation, sample counting and snapshot registers.
   assumes the sequencer delivers one sample pulse per channel conversion and one
   cycle_done pulse per conversion cycle, and the serial front end decodes commands.
*/
`timescale 1ns/1ps
`include "pad_consts.svh"

module pad_datapath #(
   parameter int NUM_CH = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input pad_pkg::pad_sample_type sample_in,
   input wire logic cycle_done,
   input pad_pkg::pad_snap_type snap_in,
   input wire logic reg_we,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] res_chan,
   input pad_pkg::pad_res_sel_type res_sel,
   output logic [`PAD_ACC_W-1:0] res_data,
   output logic [NUM_CH-1:0][1:0] perm_pos,
   output pad_pkg::pad_rate_type sample_rate,
   output logic [NUM_CH-1:0] avg_valid,
   output logic overflow_flag,
   output logic alert_ovf,
   output logic power_signed
);
   import pad_pkg::*;

   localparam int SW = `PAD_SAMPLE_W;
   localparam int PW = `PAD_PROD_W;
   localparam int AW = `PAD_ACC_W;
   localparam int CW = `PAD_CNT_W;
   localparam int RW = `PAD_PWR_W;
   localparam logic signed [AW-1:0] ACC_MAX = {1'b0, {(AW-1){1'b1}}};
   localparam logic signed [AW-1:0] ACC_MIN = {1'b1, {(AW-1){1'b0}}};
   localparam logic [CW-1:0] CNT_MAX = '1;

   typedef struct packed {
      logic [7:0] sign_fmt;
      logic [1:0] rate;
      logic alert_en;
      logic ovf;
      logic [NUM_CH-1:0][AW-1:0] acc;
      logic [CW-1:0] count;
      logic [NUM_CH-1:0][1:0] perm;
      logic [NUM_CH-1:0][SW-1:0] live_bus;
      logic [NUM_CH-1:0][SW-1:0] live_sense;
      logic [NUM_CH-1:0][PW-1:0] live_pwr;
      logic [NUM_CH-1:0][15:0] snap_bus;
      logic [NUM_CH-1:0][15:0] snap_sense;
      logic [NUM_CH-1:0][15:0] snap_bus_avg;
      logic [NUM_CH-1:0][15:0] snap_sense_avg;
      logic [NUM_CH-1:0][RW-1:0] snap_pwr;
      logic [NUM_CH-1:0][AW-1:0] snap_acc;
      logic [CW-1:0] snap_count;
      logic [7:0] reg_rdata;
      logic [AW-1:0] res_data;
   } dp_st_type;

   dp_st_type st_q;
   dp_st_type st_d;

   logic [NUM_CH-1:0][SW-1:0] avg_bus;
   logic [NUM_CH-1:0][SW-1:0] avg_sense;
   logic [NUM_CH-1:0] bus_full;
   logic [NUM_CH-1:0] sense_full;
   logic signed [PW-1:0] product;
   logic snap_any;
   logic snap_clear;
   logic bus_signed;
   logic sense_signed;
   logic sat_event;
   logic wrap_event;

   // ==========================================================
   // rolling averages, one pair of windows per channel
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_avg
      logic push;
      assign push = sample_in.valid && (sample_in.chan == 2'(ch));
      pad_avg8 #(.W(SW), .DEPTH(`PAD_AVG_DEPTH)) u_bus_avg (
         .sys_clk(sys_clk),
         .rst(rst),
         .push(push),
         .din(sample_in.bus), // RL1
         .avg(avg_bus[ch]),
         .full(bus_full[ch])
      );
      pad_avg8 #(.W(SW), .DEPTH(`PAD_AVG_DEPTH)) u_sense_avg (
         .sys_clk(sys_clk),
         .rst(rst),
         .push(push),
         .din(sample_in.sense), // RL1
         .avg(avg_sense[ch]),
         .full(sense_full[ch])
      );
      assign avg_valid[ch] = bus_full[ch] && sense_full[ch]; // RL3
   end

   // ==========================================================
   // formatting helpers
   // signed truncation drops the extra lsb so the full range stays readable
   function automatic logic [15:0] fmt16(input logic [SW-1:0] s, input logic sgn);
      fmt16 = sgn ? s[SW-1:1] : s[15:0]; // RL7 RL8 RL9
   endfunction

   function automatic logic [RW-1:0] fmt_pwr(input logic [PW-1:0] p, input logic sgn);
      fmt_pwr = sgn ? p[PW-1:PW-RW] : p[PW-2:PW-RW-1]; // RL13
   endfunction

   assign bus_signed = st_q.sign_fmt[`PAD_SFMT_BUS_BIT]; // RL6
   assign sense_signed = st_q.sign_fmt[`PAD_SFMT_SENSE_BIT]; // RL6
   assign power_signed = bus_signed || sense_signed; // RL19

   // full 17-bit sense times the top 14 bus bits, always signed
   assign product = PW'(sample_in.sense * $signed(sample_in.bus[SW-1:SW-`PAD_BUS_MSBS])); // RL10 RL11 RL5

   assign snap_any = snap_in.plain || snap_in.no_clear || snap_in.general;
   assign snap_clear = snap_in.plain || snap_in.general; // RL21

   // ==========================================================
   // next state
   always_comb begin
      logic signed [AW:0] sum;
      logic signed [AW-1:0] base;
      sum = '0;
      base = '0;
      st_d = st_q;
      sat_event = 1'b0;
      wrap_event = 1'b0;

      // register port
      if (reg_we && reg_addr == `PAD_ADDR_SIGN_FMT) begin
         st_d.sign_fmt = reg_wdata; // RL6
      end
      if (reg_we && reg_addr == `PAD_ADDR_CTRL) begin
         st_d.rate = reg_wdata[`PAD_CTRL_RATE_LSB +: 2]; // RL18
         st_d.alert_en = reg_wdata[`PAD_CTRL_ALERT_BIT];
      end
      unique case (reg_addr)
         `PAD_ADDR_CTRL: begin
            st_d.reg_rdata = {st_q.rate, 4'h0, st_q.alert_en, st_q.ovf};
         end
         `PAD_ADDR_SIGN_FMT: begin
            st_d.reg_rdata = st_q.sign_fmt;
         end
         default: begin
            st_d.reg_rdata = 8'h00;
         end
      endcase

      // snapshot latches the state from before this cycle's updates
      if (snap_any) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            st_d.snap_bus[ch] = fmt16(st_q.live_bus[ch], bus_signed); // RL2
            st_d.snap_sense[ch] = fmt16(st_q.live_sense[ch], sense_signed);
            st_d.snap_bus_avg[ch] = fmt16(avg_bus[ch], bus_signed);
            st_d.snap_sense_avg[ch] = fmt16(avg_sense[ch], sense_signed);
            st_d.snap_pwr[ch] = fmt_pwr(st_q.live_pwr[ch], power_signed);
            st_d.snap_acc[ch] = st_q.acc[ch]; // RL12
         end
         st_d.snap_count = st_q.count;
      end
      if (snap_clear) begin
         st_d.acc = '0; // RL22
         st_d.count = '0; // RL22
      end

      // conversion of one channel: product is added in the same cycle
      // after a clearing snapshot in the same cycle the sample lands on zero
      if (sample_in.valid && 32'(sample_in.chan) < NUM_CH) begin
         st_d.live_bus[sample_in.chan] = sample_in.bus;
         st_d.live_sense[sample_in.chan] = sample_in.sense;
         st_d.live_pwr[sample_in.chan] = product;
         st_d.perm[sample_in.chan] = 2'(st_q.perm[sample_in.chan] + 1'b1); // RL4
         base = snap_clear ? '0 : $signed(st_q.acc[sample_in.chan]);
         sum = (AW+1)'(base) + (AW+1)'(product); // RL20 RL11
         if (sum > (AW+1)'(ACC_MAX)) begin
            st_d.acc[sample_in.chan] = ACC_MAX; // RL16
            sat_event = 1'b1;
         end else if (sum < (AW+1)'(ACC_MIN)) begin
            st_d.acc[sample_in.chan] = ACC_MIN; // RL16
            sat_event = 1'b1;
         end else begin
            st_d.acc[sample_in.chan] = AW'(sum); // RL12
         end
      end

      // count conversion cycles; the wrap is flagged but never clears anything
      if (cycle_done) begin
         if (snap_clear) begin
            st_d.count = CW'(1);
         end else begin
            st_d.count = CW'(st_q.count + 1'b1); // RL14 RL15
            wrap_event = (st_q.count == CNT_MAX);
         end
      end

      // set wins over the clear so no overflow is lost
      st_d.ovf = (st_q.ovf && !snap_clear) || sat_event || wrap_event; // RL21 RL23

      // result read port
      unique case (res_sel)
         RES_BUS: st_d.res_data = AW'(st_q.snap_bus[res_chan]);
         RES_SENSE: st_d.res_data = AW'(st_q.snap_sense[res_chan]);
         RES_BUS_AVG: st_d.res_data = AW'(st_q.snap_bus_avg[res_chan]);
         RES_SENSE_AVG: st_d.res_data = AW'(st_q.snap_sense_avg[res_chan]);
         RES_POWER: st_d.res_data = AW'(st_q.snap_pwr[res_chan]);
         RES_ACC: st_d.res_data = st_q.snap_acc[res_chan];
         RES_COUNT: st_d.res_data = AW'(st_q.snap_count);
         default: st_d.res_data = '0;
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
         st_q.sign_fmt <= `PAD_SIGN_FMT_RST;
         st_q.rate <= 2'(`PAD_CTRL_RST >> `PAD_CTRL_RATE_LSB);
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.reg_rdata;
   assign res_data = st_q.res_data;
   assign perm_pos = st_q.perm;
   assign sample_rate = pad_rate_type'(st_q.rate);
   assign overflow_flag = st_q.ovf;
   assign alert_ovf = st_q.ovf && st_q.alert_en; // RL17

   // ==========================================================
   // assertions
   default clocking dp_cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_ovf_holds: assert property (st_q.ovf && !snap_clear |=> st_q.ovf) // RL21
      else $error("overflow flag dropped without a clearing snapshot");

   a_ovf_set_now: assert property (sat_event || wrap_event |=> st_q.ovf && overflow_flag) // RL23
      else $error("overflow flag not set in the cycle of the overflow");

   a_ovf_cleared: assert property (snap_clear && !sat_event && !wrap_event |=> !st_q.ovf) // RL21
      else $error("clearing snapshot did not clear the overflow flag");

   a_count_wraps: assert property (cycle_done && !snap_clear && st_q.count == CNT_MAX
      |=> st_q.count == '0 ##1 st_q.count == '0 || $past(cycle_done)) // RL15
      else $error("sample counter did not wrap to zero");

   a_count_steps: assert property (cycle_done && !snap_clear
      |=> st_q.count == CW'($past(st_q.count) + 1'b1)) // RL14
      else $error("sample counter did not advance by one");

   a_acc_saturate: assert property (sample_in.valid && sample_in.chan == 2'd0 && !snap_clear
      && $signed(st_q.acc[0]) == ACC_MAX && !product[PW-1] |=> $signed(st_q.acc[0]) == ACC_MAX) // RL16
      else $error("accumulator left its maximum instead of holding");

   a_acc_adds: assert property (sample_in.valid && sample_in.chan == 2'd0 && !snap_clear
      && $signed(st_q.acc[0]) > 0 && $signed(st_q.acc[0]) < 48'sh0000_1000_0000
      |=> $signed(st_q.acc[0]) == $signed($past(st_q.acc[0])) + $past(product)) // RL20
      else $error("power product not added into the accumulator");

   a_snap_stable: assert property (!snap_any |=> $stable(st_q.snap_acc) && $stable(st_q.snap_bus_avg)) // RL2
      else $error("readable results changed without a snapshot");

   a_snap_latch: assert property (snap_any |=> st_q.snap_acc[0] == $past(st_q.acc[0])
      && st_q.snap_count == $past(st_q.count)) // RL12
      else $error("snapshot did not latch the accumulator and count");

   a_clear_zero: assert property (snap_clear && !sample_in.valid && !cycle_done
      |=> st_q.acc == '0 && st_q.count == '0) // RL22
      else $error("clearing snapshot did not zero the accumulation");

   a_perm_cycle: assert property (sample_in.valid && sample_in.chan == 2'd0
      |=> st_q.perm[0] == 2'($past(st_q.perm[0]) + 1'b1)) // RL4
      else $error("permutation position did not step");

   a_alert_gate: assert property (st_q.ovf && st_q.alert_en
      |-> alert_ovf ##1 (alert_ovf || !st_q.ovf || !st_q.alert_en)) // RL17
      else $error("alert output not following the overflow flag");

   // overflow is out of reach of a short bench, so these properties are its main guard
   a_acc_floor: assert property (sample_in.valid && sample_in.chan == 2'd0 && !snap_clear
      && $signed(st_q.acc[0]) == ACC_MIN && product[PW-1] |=> $signed(st_q.acc[0]) == ACC_MIN) // RL16
      else $error("accumulator left its minimum instead of holding");

   a_sat_flags: assert property (sample_in.valid && sample_in.chan == 2'd0 && !snap_clear
      && $signed(st_q.acc[0]) == ACC_MAX && product > 0 |=> overflow_flag) // RL23
      else $error("saturation did not raise the overflow flag");

   a_alert_quiet: assert property (!st_q.ovf || !st_q.alert_en |-> !alert_ovf) // RL17
      else $error("alert raised without an enabled overflow");

   a_ovf_readable: assert property (reg_addr == `PAD_ADDR_CTRL
      |=> reg_rdata[`PAD_CTRL_OVF_BIT] == $past(overflow_flag)) // RL17
      else $error("overflow flag not readable in the control byte");

   a_count_holds: assert property (!cycle_done && !snap_clear |=> $stable(st_q.count)) // RL15
      else $error("sample counter moved without a conversion cycle");

   a_clear_restart: assert property (snap_clear && cycle_done |=> st_q.count == CW'(1)) // RL22
      else $error("sample counter did not restart at one");

   a_acc_idle: assert property (!sample_in.valid && !snap_clear |=> $stable(st_q.acc)) // RL20
      else $error("accumulator moved without a conversion");

   a_perm_idle: assert property (!sample_in.valid |=> $stable(st_q.perm)) // RL4
      else $error("permutation position moved without a conversion");

   a_avg_stays: assert property (avg_valid[0] |=> avg_valid[0]) // RL3
      else $error("average valid dropped after it was reached");

   a_fmt_write: assert property (reg_we && reg_addr == `PAD_ADDR_SIGN_FMT
      |=> st_q.sign_fmt == $past(reg_wdata)) // RL6
      else $error("sign format write did not land");

   a_rate_write: assert property (reg_we && reg_addr == `PAD_ADDR_CTRL
      |=> sample_rate == pad_rate_type'($past(reg_wdata[`PAD_CTRL_RATE_LSB +: 2]))) // RL18
      else $error("sample rate write did not land");

   a_snap_unsigned: assert property (snap_any && !bus_signed
      |=> st_q.snap_bus[0] == $past(st_q.live_bus[0][15:0])) // RL7
      else $error("unsigned bus result is not the low sixteen sample bits");

   a_res_hold: assert property (!snap_any ##1 ($stable(res_sel) && $stable(res_chan))
      |=> $stable(res_data)) // RL2
      else $error("result port changed without a snapshot or new selection");

   c_saturation: cover property (sat_event ##1 snap_in.plain);
   c_keep_flag: cover property (st_q.ovf && snap_in.no_clear ##1 st_q.ovf);
   c_count_wrap: cover property (wrap_event);
   c_avg_ready: cover property (!avg_valid[0] ##1 avg_valid[0]);
   c_general_clear: cover property (st_q.ovf && snap_in.general);

endmodule // pad_datapath

/* verif/pad_host_model.sv */
/*
   host side model: register writes and reads, and the three snapshot commands.
   assumes the bench calls its tasks and that the datapath samples on the rising edge.
*/
`timescale 1ns/1ps

module pad_host_model (
   input wire logic sys_clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_we,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output pad_pkg::pad_snap_type snap_in
);
   import pad_pkg::*;

   // ==========================================================
   // drivers, all changed on the falling edge
   initial begin
      reg_we = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      snap_in = '0;
   end

   // the rate field travels in the ctrl byte written here
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_we = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_we = 1'b0;
      // released data must not look like the last value
      reg_wdata = ~d;
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask

   task automatic snapshot(input pad_snap_type k);
      @(negedge sys_clk);
      snap_in = k;
      @(negedge sys_clk);
      snap_in = '0;
   endtask
endmodule // pad_host_model

/* verif/testbench.sv */
/*
   self-checking bench of the power accumulator datapath against an integer and queue model.
   assumes four channels; saturation and counter wrap need far longer runs than this one.
*/
`timescale 1ns/1ps
`include "pad_consts.svh"

module testbench;
   import pad_pkg::*;

   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   pad_sample_type sample_in = '0;
   logic cycle_done = 1'b0;
   pad_snap_type snap_in;
   logic reg_we;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] res_chan = 2'b00;
   pad_res_sel_type res_sel = RES_BUS;
   logic [47:0] res_data;
   logic [3:0][1:0] perm_pos;
   pad_rate_type sample_rate;
   logic [3:0] avg_valid;
   logic overflow_flag, alert_ovf, power_signed;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   int win_b[4][$], win_s[4][$];
   int nsamp[4], lbus[4], lsense[4], lprod[4];
   longint acc[4];
   int count = 0;
   logic [7:0] sfmt = 8'h00;
   logic [47:0] s_res[4][8];
   logic [7:0] rd;

   always #4 sys_clk = ~sys_clk;

   pad_datapath #(.NUM_CH(4)) dut (.sys_clk(sys_clk), .rst(rst), .sample_in(sample_in),
      .cycle_done(cycle_done), .snap_in(snap_in), .reg_we(reg_we), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .res_chan(res_chan), .res_sel(res_sel),
      .res_data(res_data), .perm_pos(perm_pos), .sample_rate(sample_rate), .avg_valid(avg_valid),
      .overflow_flag(overflow_flag), .alert_ovf(alert_ovf), .power_signed(power_signed));

   pad_host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_we(reg_we),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .snap_in(snap_in));

   // ==========================================================
   // verdict and hang guard
   task automatic conclude();
      if (failures == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         conclude();
      end
   end

   task automatic chk_val(input string name, input logic [47:0] exp, input logic [47:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   // ==========================================================
   // model helpers
   function automatic logic [47:0] f16(input int v, input bit sg);
      logic [16:0] x;
      x = 17'(v);
      return sg ? 48'(x[16:1]) : 48'(x[15:0]);
   endfunction

   function automatic logic [47:0] fpw(input int v, input bit sg);
      logic [30:0] x;
      x = 31'(v);
      return sg ? 48'(x[30:3]) : 48'(x[29:2]);
   endfunction

   task automatic push(input int c, input int b, input int s);
      @(negedge sys_clk);
      sample_in.valid = 1'b1;
      sample_in.chan = 2'(c);
      sample_in.bus = 17'(b);
      sample_in.sense = 17'(s);
      win_b[c].push_front(b);
      win_s[c].push_front(s);
      if (win_b[c].size() > 8) begin
         void'(win_b[c].pop_back());
         void'(win_s[c].pop_back());
      end
      nsamp[c]++;
      lbus[c] = b;
      lsense[c] = s;
      lprod[c] = s * (b >>> 3);
      acc[c] += lprod[c];
      @(negedge sys_clk);
      sample_in.valid = 1'b0;
      sample_in.bus = ~sample_in.bus;
      sample_in.sense = ~sample_in.sense;
      chk_val("perm_pos", 48'(nsamp[c] % 4), 48'(perm_pos[c]));
      chk_val("avg_valid", 48'(nsamp[c] >= 8), 48'(avg_valid[c]));
   endtask

   task automatic tick();
      @(negedge sys_clk);
      cycle_done = 1'b1;
      count = (count + 1) % 16777216;
      @(negedge sys_clk);
      cycle_done = 1'b0;
   endtask

   // kind 0 plain, 1 no_clear, 2 general
   task automatic snap(input int kind);
      int sb, ss;
      bit psg;
      psg = sfmt[3] | sfmt[2];
      for (int c = 0; c < 4; c++) begin
         sb = 0;
         ss = 0;
         for (int i = 0; i < win_b[c].size(); i++) begin
            sb += win_b[c][i];
            ss += win_s[c][i];
         end
         s_res[c][0] = f16(lbus[c], sfmt[3]);
         s_res[c][1] = f16(lsense[c], sfmt[2]);
         s_res[c][2] = f16(sb >>> 3, sfmt[3]);
         s_res[c][3] = f16(ss >>> 3, sfmt[2]);
         s_res[c][4] = fpw(lprod[c], psg);
         s_res[c][5] = 48'(acc[c]);
         s_res[c][6] = 48'(count);
         s_res[c][7] = 48'h0;
         if (kind != 1) begin
            acc[c] = 0;
         end
      end
      if (kind != 1) begin
         count = 0;
      end
      host.snapshot(pad_snap_type'(3'b100 >> kind));
   endtask

   task automatic chk_res(input int c, input int sel);
      @(negedge sys_clk);
      res_chan = 2'(c);
      res_sel = pad_res_sel_type'(sel);
      @(negedge sys_clk);
      chk_val($sformatf("res_data ch%0d sel%0d", c, sel), s_res[c][sel], res_data);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(41857));
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      host.read_reg(`PAD_ADDR_SIGN_FMT, rd);
      chk_val("sign_format_select", 48'h0, 48'(rd));
      host.read_reg(`PAD_ADDR_CTRL, rd);
      chk_val("ctrl", 48'h0, 48'(rd));
      host.write_reg(8'h33, 8'h55);
      host.read_reg(8'h33, rd);
      chk_val("unmapped", 48'h0, 48'(rd));
      for (int r = 0; r < 4; r++) begin
         // bit 0 written high must not reach the read-only overflow flag
         host.write_reg(`PAD_ADDR_CTRL, 8'(r << 6) | 8'h03);
         host.read_reg(`PAD_ADDR_CTRL, rd);
         chk_val("ctrl", 48'(8'(r << 6) | 8'h02), 48'(rd));
         chk_val("sample_rate", 48'(r), 48'(sample_rate));
      end
      for (int f = 0; f < 4; f++) begin
         sfmt = 8'(f << 2) | 8'ha0;
         host.write_reg(`PAD_ADDR_SIGN_FMT, sfmt);
         host.read_reg(`PAD_ADDR_SIGN_FMT, rd);
         chk_val("sign_format_select", 48'(sfmt), 48'(rd));
         chk_val("power_signed", 48'(f != 0), 48'(power_signed));
         for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 4; c++) begin
               push(c, $signed(17'($urandom)), $signed(17'($urandom)));
            end
            tick();
         end
         snap(f % 3);
         for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 8; s++) begin
               chk_res(c, s);
            end
         end
         // a live sample must not leak into the readable results
         push(0, $signed(17'($urandom)), $signed(17'($urandom)));
         chk_res(0, 0);
         chk_res(0, 5);
      end
      // no saturation or wrap occurs in this run, so the flag must stay clear
      chk_val("overflow_flag", 48'h0, 48'(overflow_flag));
      chk_val("alert_ovf", 48'h0, 48'(alert_ovf));
      conclude();
   end
endmodule // testbench
